// ---- rtl/mea_pkg.sv ----
// Shared constants of the main event summary and mask block
package mea_pkg;

    // Register port geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;

    // Register addresses, byte offsets as printed
    localparam logic [ADDR_W-1:0] SUMMARY_ADDR = 32'h5000_180C;
    localparam logic [ADDR_W-1:0] MASK_ADDR    = 32'h5000_180E;

    // Reset values
    localparam logic [DATA_W-1:0] SUMMARY_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] MASK_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] READ_IDLE     = 16'h0000;

    // Summary / mask bit positions
    localparam int CHARGER_BIT   = 11;
    localparam int EP0_NEGACK_BIT = 10;
    localparam int EP0_RX_BIT    = 9;
    localparam int EP0_TX_BIT    = 8;
    localparam int MASTER_BIT    = 7;
    localparam int RX_BIT        = 6;
    localparam int LOCK_BIT      = 5;
    localparam int NEGACK_BIT    = 4;
    localparam int FRAME_BIT     = 3;
    localparam int TX_BIT        = 2;
    localparam int SECONDARY_BIT = 1;
    localparam int WARNING_BIT   = 0;

    // Bits that hold a real summary flag (bit 7 and 15:12 read zero)
    localparam logic [DATA_W-1:0] EVENT_BITS    = 16'h0F7F;
    // Bits of the mask register that software can write
    localparam logic [DATA_W-1:0] MASK_WRITABLE = 16'h0FFF;

    // Source field widths
    localparam int CHARGER_W   = 3;
    localparam int SECONDARY_W = 5;

endpackage : mea_pkg

// ---- rtl/mea_sticky_bit.sv ----
// One summary flag: set wins over clear, synchronous reset
`timescale 1ns/1ps
module mea_sticky_bit
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Control
    input  wire logic set_in,
    input  wire logic clear_in,
    // State
    output logic      flag_out
);

    logic flag_r;
    logic flag_nxt;

    // An event in the clearing cycle must survive the clear
    assign flag_nxt = set_in ? 1'b1 : (clear_in ? 1'b0 : flag_r);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

    assign flag_out = flag_r;

endmodule // mea_sticky_bit

// ---- rtl/mea_main_event.sv ----
// Main event summary, main event mask and interrupt output
//
// Operation
// RQ1: The charger summary bit 11 sets when any of the three low charger status bits changes and clears on a read of the charger status register.
// RQ2: The endpoint-zero NAK summary bit 10 follows the OR of the OUT and IN NAK flags and clears on a read of that NAK register.
// RQ3: The endpoint-zero receive summary bit 9 follows the last-packet-received flag and clears on a read of that receive status register.
// RQ4: The endpoint-zero transmit summary bit 8 follows the transmit-done flag and clears on a read of that transmit status register.
// RQ5: Summary bit 7 always reads zero while mask bit 7 is the master interrupt enable.
// RQ6: The receive summary bit 6 sets on any unmasked receive event and clears only once all last-received and overrun flags are zero.
// RQ7: The lock-change summary bit 5 sets on any move between locked and unlocked and clears on a read of the summary register.
// RQ8: The NAK summary bit 4 sets on any unmasked NAK event and clears on a read of the NAK event register.
// RQ9: The frame summary bit 3 sets whenever the frame counter takes a new value and clears on a read of the summary register.
// RQ10: The transmit summary bit 2 sets on any unmasked transmit event and clears only once all done and underrun flags are zero.
// RQ11: The secondary summary bit 1 shows an unmasked secondary event and clears on a read of the secondary event register.
// RQ12: The warning summary bit 0 shows an unmasked FIFO warning event and clears on a read of the warning event register.
// RQ13: Each mask bit sits at its summary bit position, one enabling and zero suppressing the interrupt.
// RQ14: A secondary event sets the secondary summary bit only while its own secondary mask bit is one.
// RQ15: The interrupt is raised when the master enable is one and some summary bit is one with its mask bit one.
// RQ16: Bits 15 to 12 of both registers read zero and ignore writes.
`timescale 1ns/1ps
module mea_main_event
    import mea_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          reset_in,
    // Register port
    input  wire logic [mea_pkg::ADDR_W-1:0]    reg_addr_in,
    input  wire logic [mea_pkg::DATA_W-1:0]    reg_wdata_in,
    input  wire logic                          reg_write_in,
    input  wire logic                          reg_read_in,
    output logic      [mea_pkg::DATA_W-1:0]    reg_rdata_out,
    // Charger status
    input  wire logic [mea_pkg::CHARGER_W-1:0] charger_status_in,
    input  wire logic                          charger_status_read_in,
    // Endpoint zero
    input  wire logic                          ep_zero_out_negack_in,
    input  wire logic                          ep_zero_in_negack_in,
    input  wire logic                          ep_zero_negack_register_read_in,
    input  wire logic                          ep_zero_rx_last_in,
    input  wire logic                          ep_zero_receive_status_read_in,
    input  wire logic                          ep_zero_tx_done_in,
    input  wire logic                          ep_zero_transmit_status_read_in,
    // Receive event roll-up
    input  wire logic                          receive_event_unmasked_in,
    input  wire logic                          receive_pending_in,
    // Transmit event roll-up
    input  wire logic                          transmit_event_unmasked_in,
    input  wire logic                          transmit_pending_in,
    // Frame timer
    input  wire logic                          frame_timer_unlocked_flag_in,
    input  wire logic                          frame_update_in,
    // NAK event roll-up
    input  wire logic                          negack_event_unmasked_in,
    input  wire logic                          negack_event_register_read_in,
    // Secondary events and their masks
    input  wire logic [mea_pkg::SECONDARY_W-1:0] secondary_event_in,
    input  wire logic [mea_pkg::SECONDARY_W-1:0] secondary_mask_in,
    input  wire logic                          secondary_event_register_read_in,
    // FIFO warning roll-up
    input  wire logic                          fifo_warning_unmasked_in,
    input  wire logic                          fifo_warning_event_register_read_in,
    // Outputs
    output logic      [mea_pkg::DATA_W-1:0]    main_event_summary_out,
    output logic      [mea_pkg::DATA_W-1:0]    main_event_mask_out,
    output logic                               irq_out
);

    import mea_pkg::*;

    // Registered state and its next-state values
    logic [DATA_W-1:0]    mask_r;
    logic [DATA_W-1:0]    mask_nxt;
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    rdata_nxt;
    logic                 irq_r;
    logic                 irq_nxt;
    logic                 primed_r;
    logic [CHARGER_W-1:0] charger_prev_r;
    logic                 ep0_negack_prev_r;
    logic                 ep0_rx_prev_r;
    logic                 ep0_tx_prev_r;
    logic                 unlocked_prev_r;
    logic                 negack_prev_r;
    logic                 secondary_prev_r;
    logic                 warning_prev_r;

    // Decode and event wires
    wire logic              summary_sel;
    wire logic              mask_sel;
    wire logic              summary_read;
    wire logic              mask_write;
    wire logic              ep0_negack_any;
    wire logic              secondary_any;
    wire logic              charger_changed;
    wire logic              ep0_negack_rise;
    wire logic              ep0_rx_rise;
    wire logic              ep0_tx_rise;
    wire logic              lock_changed;
    wire logic              negack_rise;
    wire logic              secondary_rise;
    wire logic              warning_rise;
    wire logic [DATA_W-1:0] set_vec;
    wire logic [DATA_W-1:0] clear_vec;
    wire logic [DATA_W-1:0] summary_w;
    wire logic [DATA_W-1:0] pending_w;

    // Address decode
    assign summary_sel  = (reg_addr_in == SUMMARY_ADDR);
    assign mask_sel     = (reg_addr_in == MASK_ADDR);
    assign summary_read = reg_read_in & summary_sel;
    assign mask_write   = reg_write_in & mask_sel;

    // Source combination
    // RQ2 OR of NAK flags
    assign ep0_negack_any = ep_zero_out_negack_in | ep_zero_in_negack_in;
    // RQ14 secondary mask gating
    assign secondary_any  = |(secondary_event_in & secondary_mask_in);

    // Edges are suppressed for one cycle after reset, so the
    // first sample only seeds the history and fakes no event.
    // RQ1 charger change
    assign charger_changed = primed_r & (charger_status_in != charger_prev_r);
    assign ep0_negack_rise = primed_r & ep0_negack_any & ~ep0_negack_prev_r;
    // RQ3 receive flag rise
    assign ep0_rx_rise     = primed_r & ep_zero_rx_last_in & ~ep0_rx_prev_r;
    // RQ4 transmit flag rise
    assign ep0_tx_rise     = primed_r & ep_zero_tx_done_in & ~ep0_tx_prev_r;
    // RQ7 either direction
    assign lock_changed    = primed_r & (frame_timer_unlocked_flag_in ^ unlocked_prev_r);
    // RQ8 unmasked NAK
    assign negack_rise     = primed_r & negack_event_unmasked_in & ~negack_prev_r;
    // RQ11 unmasked secondary
    assign secondary_rise  = primed_r & secondary_any & ~secondary_prev_r;
    // RQ12 unmasked warning
    assign warning_rise    = primed_r & fifo_warning_unmasked_in & ~warning_prev_r;

    // Set terms per summary bit
    assign set_vec[DATA_W-1:CHARGER_BIT+1] = '0;
    assign set_vec[CHARGER_BIT]    = charger_changed;
    assign set_vec[EP0_NEGACK_BIT] = ep0_negack_rise;
    assign set_vec[EP0_RX_BIT]     = ep0_rx_rise;
    assign set_vec[EP0_TX_BIT]     = ep0_tx_rise;
    assign set_vec[MASTER_BIT]     = 1'b0;
    // RQ6 receive roll-up set
    assign set_vec[RX_BIT]         = receive_event_unmasked_in;
    assign set_vec[LOCK_BIT]       = lock_changed;
    assign set_vec[NEGACK_BIT]     = negack_rise;
    // RQ9 frame counter update
    assign set_vec[FRAME_BIT]      = frame_update_in;
    // RQ10 transmit roll-up set
    assign set_vec[TX_BIT]         = transmit_event_unmasked_in;
    assign set_vec[SECONDARY_BIT]  = secondary_rise;
    assign set_vec[WARNING_BIT]    = warning_rise;

    // Clear terms per summary bit
    assign clear_vec[DATA_W-1:CHARGER_BIT+1] = '0;
    // RQ1 cleared by charger read
    assign clear_vec[CHARGER_BIT]    = charger_status_read_in;
    // RQ2 cleared by NAK read
    assign clear_vec[EP0_NEGACK_BIT] = ep_zero_negack_register_read_in;
    // RQ3 cleared by status read
    assign clear_vec[EP0_RX_BIT]     = ep_zero_receive_status_read_in;
    // RQ4 cleared by status read
    assign clear_vec[EP0_TX_BIT]     = ep_zero_transmit_status_read_in;
    assign clear_vec[MASTER_BIT]     = 1'b0;
    // RQ6 clears once nothing pending
    assign clear_vec[RX_BIT]         = ~receive_pending_in;
    // RQ7 cleared by summary read
    assign clear_vec[LOCK_BIT]       = summary_read;
    // RQ8 cleared by NAK event read
    assign clear_vec[NEGACK_BIT]     = negack_event_register_read_in;
    // RQ9 cleared by summary read
    assign clear_vec[FRAME_BIT]      = summary_read;
    // RQ10 clears once nothing pending
    assign clear_vec[TX_BIT]         = ~transmit_pending_in;
    // RQ11 cleared by secondary read
    assign clear_vec[SECONDARY_BIT]  = secondary_event_register_read_in;
    // RQ12 cleared by warning read
    assign clear_vec[WARNING_BIT]    = fifo_warning_event_register_read_in;

    // One sticky cell per real summary bit
    genvar i;
    generate
        for (i = 0; i < DATA_W; i = i + 1)
        begin : g_summary
            if (EVENT_BITS[i])
            begin : g_flag
                mea_sticky_bit u_flag
                (
                    .clk_in   (clk_in),
                    .reset_in (reset_in),
                    .set_in   (set_vec[i]),
                    .clear_in (clear_vec[i]),
                    .flag_out (summary_w[i])
                );
            end
            else
            begin : g_zero
                // RQ5 bit 7 hardwired
                // RQ16 reserved reads zero
                assign summary_w[i] = 1'b0;
            end
        end
    endgenerate

    // Mask register
    // RQ16 reserved writes dropped
    assign mask_nxt = mask_write ? (reg_wdata_in & MASK_WRITABLE) : mask_r;

    // Read data stand only in the cycle after the strobe
    assign rdata_nxt = summary_read               ? summary_w :
                       (reg_read_in & mask_sel)   ? mask_r    :
                                                    READ_IDLE;

    // RQ13 per-bit mask gating
    assign pending_w = summary_w & mask_r & EVENT_BITS;
    // RQ15 master enable gating
    assign irq_nxt   = mask_r[MASTER_BIT] & (|pending_w);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mask_r  <= MASK_RESET;
            rdata_r <= READ_IDLE;
            irq_r   <= 1'b0;
        end
        else
        begin
            mask_r  <= mask_nxt;
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Source history for edge detection
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            primed_r          <= 1'b0;
            charger_prev_r    <= '0;
            ep0_negack_prev_r <= 1'b0;
            ep0_rx_prev_r     <= 1'b0;
            ep0_tx_prev_r     <= 1'b0;
            unlocked_prev_r   <= 1'b0;
            negack_prev_r     <= 1'b0;
            secondary_prev_r  <= 1'b0;
            warning_prev_r    <= 1'b0;
        end
        else
        begin
            primed_r          <= 1'b1;
            charger_prev_r    <= charger_status_in;
            ep0_negack_prev_r <= ep0_negack_any;
            ep0_rx_prev_r     <= ep_zero_rx_last_in;
            ep0_tx_prev_r     <= ep_zero_tx_done_in;
            unlocked_prev_r   <= frame_timer_unlocked_flag_in;
            negack_prev_r     <= negack_event_unmasked_in;
            secondary_prev_r  <= secondary_any;
            warning_prev_r    <= fifo_warning_unmasked_in;
        end
    end

    // Outputs; summary is the sticky cells' own flops
    assign reg_rdata_out          = rdata_r;
    assign main_event_summary_out = summary_w;
    assign main_event_mask_out    = mask_r;
    assign irq_out                = irq_r;

endmodule // mea_main_event

// ---- verif/mea_main_event_sva.sv ----
// Concurrent checks on the main event summary block ports
`timescale 1ns/1ps
module mea_main_event_sva
    import mea_pkg::*;
(
    // Clock and reset
    input wire logic                              clk_in,
    input wire logic                              reset_in,
    // Watched ports
    input wire logic [mea_pkg::ADDR_W-1:0]        reg_addr_in,
    input wire logic [mea_pkg::DATA_W-1:0]        reg_wdata_in,
    input wire logic                              reg_write_in,
    input wire logic                              reg_read_in,
    input wire logic [mea_pkg::DATA_W-1:0]        reg_rdata_out,
    input wire logic [mea_pkg::CHARGER_W-1:0]     charger_status_in,
    input wire logic                              frame_update_in,
    input wire logic                              frame_timer_unlocked_flag_in,
    input wire logic                              receive_pending_in,
    input wire logic                              receive_event_unmasked_in,
    input wire logic [mea_pkg::SECONDARY_W-1:0]   secondary_event_in,
    input wire logic [mea_pkg::SECONDARY_W-1:0]   secondary_mask_in,
    input wire logic [mea_pkg::DATA_W-1:0]        main_event_summary_out,
    input wire logic [mea_pkg::DATA_W-1:0]        main_event_mask_out,
    input wire logic                              irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Edge detectors only see changes once seeded after reset
    logic [1:0] prime_r;
    always_ff @(posedge clk_in) prime_r <= reset_in ? 2'h0 : {prime_r[0], 1'b1};
    wire logic [DATA_W-1:0] sum = main_event_summary_out;
    sequence s_sum_read; reg_read_in && reg_addr_in == SUMMARY_ADDR; endsequence
    sequence s_mask_write; reg_write_in && reg_addr_in == MASK_ADDR; endsequence
    property p_zero_bits; (sum & ~EVENT_BITS) == 16'h0000 && main_event_mask_out[15:12] == 4'h0;
    endproperty
    property p_mask_write; s_mask_write |=> main_event_mask_out == ($past(reg_wdata_in) & MASK_WRITABLE);
    endproperty
    property p_read_data; s_sum_read |=> reg_rdata_out == $past(sum); endproperty
    property p_irq; irq_out == $past(main_event_mask_out[MASTER_BIT]
        && |(sum & main_event_mask_out & EVENT_BITS)); endproperty
    property p_frame; frame_update_in |=> sum[FRAME_BIT]; endproperty
    property p_frame_clear; s_sum_read ##0 !frame_update_in |=> !sum[FRAME_BIT]; endproperty
    property p_lock; prime_r[1] && $changed(frame_timer_unlocked_flag_in) |=> sum[LOCK_BIT];
    endproperty
    property p_charger; prime_r[1] && $changed(charger_status_in) |=> sum[CHARGER_BIT]; endproperty
    property p_rx_hold; sum[RX_BIT] && receive_pending_in |=> sum[RX_BIT]; endproperty
    property p_rx_clear; !receive_pending_in && !receive_event_unmasked_in |=> !sum[RX_BIT];
    endproperty
    property p_secondary; (secondary_event_in & secondary_mask_in) == 5'h00 && !sum[SECONDARY_BIT]
        |=> !sum[SECONDARY_BIT]; endproperty
    a_zero_bits:
        assert property (p_zero_bits) else $error("reserved bit set");
    a_mask_write:
        assert property (p_mask_write) else $error("mask write lost");
    a_read_data:
        assert property (p_read_data) else $error("summary read data wrong");
    a_irq:
        assert property (p_irq) else $error("interrupt level wrong");
    a_frame:
        assert property (p_frame) else $error("frame summary not set");
    a_frame_clear:
        assert property (p_frame_clear) else $error("frame summary not cleared");
    a_lock:
        assert property (p_lock) else $error("lock change summary not set");
    a_charger:
        assert property (p_charger) else $error("charger summary not set");
    a_rx_hold:
        assert property (p_rx_hold) else $error("receive summary dropped early");
    a_rx_clear:
        assert property (p_rx_clear) else $error("receive summary not cleared");
    a_secondary:
        assert property (p_secondary) else $error("masked secondary event set summary");
endmodule // mea_main_event_sva

bind mea_main_event mea_main_event_sva i_mea_main_event_sva (.clk_in(clk_in),
    .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .charger_status_in(charger_status_in), .frame_update_in(frame_update_in),
    .frame_timer_unlocked_flag_in(frame_timer_unlocked_flag_in),
    .receive_pending_in(receive_pending_in),
    .receive_event_unmasked_in(receive_event_unmasked_in),
    .secondary_event_in(secondary_event_in), .secondary_mask_in(secondary_mask_in),
    .main_event_summary_out(main_event_summary_out),
    .main_event_mask_out(main_event_mask_out), .irq_out(irq_out));

// ---- verif/mea_cpu_model.sv ----
// Processor side: counts the interrupt requests it takes
`timescale 1ns/1ps
module mea_cpu_model
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Interrupt line and requests taken
    input  wire logic irq_in,
    output int        taken_out
);
    logic irq_r;
    always_ff @(posedge clk_in)
    begin
        irq_r     <= reset_in ? 1'b0 : irq_in;
        taken_out <= reset_in ? 0 : taken_out + int'(irq_in && !irq_r);
    end
endmodule // mea_cpu_model

// ---- verif/usb_main_event_aggregator_test.sv ----
// Self-checking bench for the main event summary block
`timescale 1ns/1ps
module usb_main_event_aggregator_test;
    import mea_pkg::*;
    logic                     clk_in = 1'b0;
    logic                     reset_in = 1'b1;
    logic [ADDR_W-1:0]        addr = '0;
    logic [DATA_W-1:0]        wdata = '0;
    logic                     wr_s = 1'b0;
    logic                     rd_s = 1'b0;
    logic                     rd_d = 1'b0;
    logic [DATA_W-1:0]        rdata;
    logic [DATA_W-1:0]        summary;
    logic [DATA_W-1:0]        mask;
    logic                     irq;
    logic [CHARGER_W-1:0]     chg = '0;
    logic [SECONDARY_W-1:0]   sec_ev = '0;
    logic [SECONDARY_W-1:0]   sec_msk = '0;
    // Source levels and read pulses, indexed by summary bit except src[7], which is the endpoint-zero IN NAK flag
    logic [11:0]              src = '0;
    logic [11:0]              clr = '0;
    logic                     rx_pend = 1'b0;
    logic                     tx_pend = 1'b0;
    logic                     unl = 1'b0;
    logic [DATA_W-1:0]        exp_q[$];
    int                       err_total = 0;
    int                       n_tests = 0;
    int                       cycles = 0;
    int                       irq_want = 0;
    int                       irq_taken;
    int                       bits[11] = '{11, 10, 9, 8, 6, 5, 4, 3, 2, 1, 0};

    mea_main_event i_mea_main_event (.clk_in(clk_in), .reset_in(reset_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
        .reg_rdata_out(rdata), .charger_status_in(chg), .charger_status_read_in(clr[11]),
        .ep_zero_out_negack_in(src[10]), .ep_zero_in_negack_in(src[7]),
        .ep_zero_negack_register_read_in(clr[10]), .ep_zero_rx_last_in(src[9]),
        .ep_zero_receive_status_read_in(clr[9]), .ep_zero_tx_done_in(src[8]),
        .ep_zero_transmit_status_read_in(clr[8]), .receive_event_unmasked_in(src[6]),
        .receive_pending_in(rx_pend), .transmit_event_unmasked_in(src[2]),
        .transmit_pending_in(tx_pend), .frame_timer_unlocked_flag_in(unl),
        .frame_update_in(src[3]), .negack_event_unmasked_in(src[4]),
        .negack_event_register_read_in(clr[4]), .secondary_event_in(sec_ev),
        .secondary_mask_in(sec_msk), .secondary_event_register_read_in(clr[1]),
        .fifo_warning_unmasked_in(src[0]), .fifo_warning_event_register_read_in(clr[0]),
        .main_event_summary_out(summary), .main_event_mask_out(mask), .irq_out(irq));
    mea_cpu_model i_mea_cpu_model (.clk_in(clk_in), .reset_in(reset_in), .irq_in(irq),
        .taken_out(irq_taken));

    initial forever #50 clk_in = ~clk_in;

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic look(input logic [DATA_W-1:0] es, input logic ei);
        @(posedge clk_in);
        @(negedge clk_in);
        check(summary, es);
        check({15'h0000, irq}, {15'h0000, ei});
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_in);
        rd_s <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_s <= 1'b0;
    endtask

    // Raise the cause of summary bit k for one cycle; toggled sources keep their new level
    task automatic fire(input int k, input logic [DATA_W-1:0] es, input logic ei);
        @(posedge clk_in);
        src <= (k == 10 && $urandom_range(1) == 1) ? 12'h080 : 12'h001 << k;
        if (k == 11) chg <= chg ^ 3'($urandom_range(7, 1));
        if (k == 1) sec_ev <= 5'($urandom_range(31, 1));
        if (k == 5) unl <= ~unl;
        if (k == 6) rx_pend <= 1'b1;
        if (k == 2) tx_pend <= 1'b1;
        @(posedge clk_in);
        src <= '0;
        sec_ev <= '0;
        irq_want += int'(ei);
        look(es, ei);
    endtask

    task automatic clear(input int k);
        @(posedge clk_in);
        if (k == 5 || k == 3) rd(SUMMARY_ADDR, 16'h0001 << k);
        else if (k == 6) rx_pend <= 1'b0;
        else if (k == 2) tx_pend <= 1'b0;
        else clr <= 12'h001 << k;
        @(posedge clk_in);
        clr <= '0;
        look(16'h0000, 1'b0);
    endtask

    task results;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_in) rd_d <= rd_s;
    always @(negedge clk_in) if (rd_d) check(rdata, exp_q.pop_front());

    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        void'($urandom(43));
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(SUMMARY_ADDR, SUMMARY_RESET);
        rd(MASK_ADDR, MASK_RESET);
        rd(32'h5000_1810, READ_IDLE);
        wr(SUMMARY_ADDR, 16'hFFFF);
        rd(SUMMARY_ADDR, 16'h0000);
        wr(MASK_ADDR, 16'hFFFF);
        rd(MASK_ADDR, 16'h0FFF);
        @(negedge clk_in);
        check(mask, 16'h0FFF);
        sec_msk <= 5'h1F;
        $display("register access test done");
        // One bit at a time: a summary read clears bits 5 and 3 together,
        // and each fire must give the processor a fresh interrupt edge
        foreach (bits[i])
        begin
            fire(bits[i], 16'h0001 << bits[i], 1'b1);
            clear(bits[i]);
        end
        fire(5, 16'h0020, 1'b1);
        clear(5);
        $display("event test done");
        wr(MASK_ADDR, 16'h0F77);
        fire(3, 16'h0008, 1'b0);
        wr(MASK_ADDR, 16'h0F7F);
        look(16'h0008, 1'b0);
        wr(MASK_ADDR, 16'hFFFF);
        irq_want++;
        look(16'h0008, 1'b1);
        clear(3);
        sec_msk <= 5'h00;
        fire(1, 16'h0000, 1'b0);
        check(16'(irq_taken), 16'(irq_want));
        $display("mask test done");
        results();
    end
endmodule // usb_main_event_aggregator_test
